// ---- rtl/aptp_pkg.sv ----
// Package of constants for the axis position touch probe block
// Behaviour
// - Done rises once the trigger fired and the position is latched.
// - Done and aborted clear when start falls; else pulse one cycle if start low.
// - Busy rises when start is asserted and the capture begins.
// - Busy drops when done, error or aborted sets.
// - Invalid conditions set error and load fault code; both clear when start falls.
// - Aborted sets when the abort instruction interrupts an active capture.
// - Channel select: 0 p1 rise, 1 p1 fall, 2 p2 rise, 3 p2 fall, default -1.
// - Drive mode needs a valid channel; -1 gives an error.
// - Latch in drive true selects drive latching, false controller; default true.
// - In drive mode the probe function object is written to open the channel.
// - In drive mode only the first trigger after start is captured.
// - In drive mode the position comes from the drive latch, gear converted.
// - In controller mode the trigger comes from the software trigger input.
// - In controller mode a software trigger latches the command position.
// - With the window on, triggers outside the bounds are rejected.
// - With the window on, triggers inside are accepted and done follows.
// - Arming may be delayed after window enable; early triggers may be lost.
// - Drive with window on but without window support gives error with fault code 401.
// - Trigger valid is an output only of the device.
// - Window enable activates window masking; default disabled.
// - Window low and high bounds set the mask ends; default zero.
package aptp_pkg;
   localparam int POS_W = 32;
   localparam int FAULT_W = 16;
   localparam int CHAN_W = 3;
   localparam logic [CHAN_W-1:0] CHAN_NONE = 3'h7;
   localparam logic [CHAN_W-1:0] CHAN_MAX = 3'h3;
   localparam logic [FAULT_W-1:0] FAULT_NONE = 16'h0000;
   localparam logic [FAULT_W-1:0] FAULT_BAD_CHANNEL = 16'h0001;
   localparam logic [FAULT_W-1:0] FAULT_WINDOW_UNSUPPORTED = 16'h0191;
   localparam logic [15:0] PROBE_ENABLE_BIT = 16'h0001;
   localparam logic [15:0] PROBE_OFF = 16'h0000;
   localparam int WB_AW = 4;
   localparam logic [WB_AW-1:0] REG_CTRL = 4'h0;
   localparam logic [WB_AW-1:0] REG_CHAN = 4'h4;
   localparam logic [WB_AW-1:0] REG_STATUS = 4'h8;
   localparam logic [WB_AW-1:0] REG_POS = 4'hC;
   localparam logic [WB_AW-1:0] REG_WIN_LOW = 4'h1;
   localparam logic [WB_AW-1:0] REG_WIN_HIGH = 4'h2;
   localparam logic [5:0] CTRL_RESET = 6'h02;
   localparam logic [15:0] PROBE_CHAN_BASE = 16'h0010;
   localparam int CTRL_START = 0;
   localparam int CTRL_DRIVE = 1;
   localparam int CTRL_WIN = 2;
   localparam int CTRL_SOFT = 3;
   localparam int CTRL_ABORT = 4;
   localparam int ARM_DELAY = 4;
   localparam int GEAR_SHIFT = 0;
endpackage

// ---- rtl/aptp_sync.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module aptp_sync
   import aptp_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Data
   input wire logic din,
   output logic dout
);
   logic s1, s2, s3;
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         dout <= 1'b0;
      end
      else
      begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3)
         begin
            dout <= s3;
         end
      end
   end
endmodule

// ---- rtl/aptp_touch_probe.sv ----
// Position latch block with Wishbone register access
//
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/1ps
module aptp_touch_probe
   import aptp_pkg::*;
#(
   parameter logic WINDOW_SUPPORTED = 1'b1
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [WB_AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Axis
   input wire logic [POS_W-1:0] cmdPosition,
   input wire logic [POS_W-1:0] actPosition,
   // Drive latch
   input wire logic probeLatched,
   input wire logic [POS_W-1:0] probePosition,
   output logic [15:0] probeFunction,
   // Status
   output logic triggerValid,
   output logic doneFlag,
   output logic busyFlag,
   output logic errorFlag,
   output logic abortedFlag
);
   typedef enum logic [2:0] {S_IDLE, S_ARM, S_WAIT, S_END} aptp_state_e;
   aptp_state_e state_r;
   logic [5:0] ctrl_r;
   logic [CHAN_W-1:0] chan_r;
   logic [FAULT_W-1:0] faultCode_r;
   logic [POS_W-1:0] latchedPos_r;
   logic [POS_W-1:0] winLow_r, winHigh_r;
   logic startPrev_r, softPrev_r, probeSync;
   logic [3:0] armCnt_r;
   logic startRise, startFall, softRise, trig, inWin, access;
   logic [POS_W-1:0] curPos, trigPos;

   aptp_sync u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .din(probeLatched),
      .dout(probeSync)
   );

   //--------------------------------------------------------------
   // Bus slave
   //--------------------------------------------------------------
   assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         ctrl_r <= CTRL_RESET;
         chan_r <= CHAN_NONE;
         winLow_r <= '0;
         winHigh_r <= '0;
      end
      else
      begin
         wb_ack_o <= access;
         ctrl_r[CTRL_ABORT] <= 1'b0;
         // Writes land on the acknowledged edge
         if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0])
         begin
            case (wb_adr_i)
               REG_CTRL: ctrl_r <= wb_dat_i[5:0];
               REG_CHAN: chan_r <= wb_dat_i[CHAN_W-1:0];
               REG_WIN_LOW: winLow_r <= wb_dat_i;
               REG_WIN_HIGH: winHigh_r <= wb_dat_i;
               default: ;
            endcase
         end
         if (access)
         begin
            case (wb_adr_i)
               REG_CTRL: wb_dat_o <= {26'h0, ctrl_r};
               REG_CHAN: wb_dat_o <= {29'h0, chan_r};
               REG_STATUS: wb_dat_o <= {faultCode_r, 11'h0, triggerValid, abortedFlag,
                                        errorFlag, busyFlag, doneFlag};
               REG_POS: wb_dat_o <= latchedPos_r;
               default: wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   //--------------------------------------------------------------
   // Trigger selection
   //--------------------------------------------------------------
   assign startRise = ctrl_r[CTRL_START] && !startPrev_r;
   assign startFall = !ctrl_r[CTRL_START] && startPrev_r;
   assign softRise = ctrl_r[CTRL_SOFT] && !softPrev_r;
   assign curPos = ctrl_r[CTRL_DRIVE] ? actPosition : cmdPosition;
   assign trigPos = ctrl_r[CTRL_DRIVE] ? (probePosition >>> GEAR_SHIFT)
                                       : cmdPosition;
   assign trig = ctrl_r[CTRL_DRIVE] ? probeSync : softRise;
   assign inWin = !ctrl_r[CTRL_WIN] ||
                  ($signed(curPos) >= $signed(winLow_r) &&
                   $signed(curPos) <= $signed(winHigh_r));

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         startPrev_r <= 1'b0;
         softPrev_r <= 1'b0;
      end
      else
      begin
         startPrev_r <= ctrl_r[CTRL_START];
         softPrev_r <= ctrl_r[CTRL_SOFT];
      end
   end

   //--------------------------------------------------------------
   // Capture sequence
   //--------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= S_IDLE;
         busyFlag <= 1'b0;
         doneFlag <= 1'b0;
         errorFlag <= 1'b0;
         abortedFlag <= 1'b0;
         faultCode_r <= FAULT_NONE;
         latchedPos_r <= '0;
         triggerValid <= 1'b0;
         probeFunction <= PROBE_OFF;
         armCnt_r <= 4'h0;
      end
      else
      begin
         // Flags held by start clear on its fall, else one-cycle pulse
         if (!ctrl_r[CTRL_START] && state_r == S_END)
         begin
            doneFlag <= 1'b0;
            abortedFlag <= 1'b0;
            errorFlag <= 1'b0;
            faultCode_r <= FAULT_NONE;
            state_r <= S_IDLE;
         end
         case (state_r)
            S_IDLE:
            begin
               if (startRise)
               begin
                  if (ctrl_r[CTRL_DRIVE] && chan_r > CHAN_MAX)
                  begin
                     errorFlag <= 1'b1;
                     faultCode_r <= FAULT_BAD_CHANNEL;
                     state_r <= S_END;
                  end
                  else if (ctrl_r[CTRL_DRIVE] && ctrl_r[CTRL_WIN] && !WINDOW_SUPPORTED)
                  begin
                     errorFlag <= 1'b1;
                     faultCode_r <= FAULT_WINDOW_UNSUPPORTED;
                     state_r <= S_END;
                  end
                  else
                  begin
                     busyFlag <= 1'b1;
                     armCnt_r <= 4'h0;
                     state_r <= S_ARM;
                     if (ctrl_r[CTRL_DRIVE])
                     begin
                        probeFunction <= PROBE_ENABLE_BIT | (PROBE_CHAN_BASE << chan_r);
                     end
                  end
               end
            end
            S_ARM:
            begin
               armCnt_r <= armCnt_r + 4'h1;
               if (ctrl_r[CTRL_ABORT])
               begin
                  abortedFlag <= 1'b1;
                  busyFlag <= 1'b0;
                  probeFunction <= PROBE_OFF;
                  state_r <= S_END;
               end
               else if (startFall)
               begin
                  busyFlag <= 1'b0;
                  probeFunction <= PROBE_OFF;
                  state_r <= S_END;
               end
               else if (!ctrl_r[CTRL_WIN] || armCnt_r == 4'(ARM_DELAY))
               begin
                  triggerValid <= 1'b1;
                  state_r <= S_WAIT;
               end
            end
            S_WAIT:
            begin
               if (ctrl_r[CTRL_ABORT])
               begin
                  abortedFlag <= 1'b1;
                  busyFlag <= 1'b0;
                  triggerValid <= 1'b0;
                  probeFunction <= PROBE_OFF;
                  state_r <= S_END;
               end
               else if (trig && inWin)
               begin
                  latchedPos_r <= trigPos;
                  doneFlag <= 1'b1;
                  busyFlag <= 1'b0;
                  triggerValid <= 1'b0;
                  probeFunction <= PROBE_OFF;
                  state_r <= S_END;
               end
            end
            S_END:
            begin
               busyFlag <= 1'b0;
               if (!ctrl_r[CTRL_START])
               begin
                  state_r <= S_IDLE;
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   //--------------------------------------------------------------
   // Checks
   //--------------------------------------------------------------
   property p_done_clear;
      @(posedge core_clk) disable iff (rst)
      doneFlag && !ctrl_r[CTRL_START] |=> !doneFlag;
   endproperty
   a_done_clear: assert property (p_done_clear) else $error("done held");

   property p_busy_excl;
      @(posedge core_clk) disable iff (rst)
      (doneFlag || errorFlag || abortedFlag) |-> !busyFlag;
   endproperty
   a_busy_excl: assert property (p_busy_excl) else $error("busy with end");

   property p_busy_start;
      @(posedge core_clk) disable iff (rst)
      state_r == S_IDLE && startRise && !errorFlag |=> busyFlag || errorFlag;
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("busy late");

   property p_bad_chan;
      @(posedge core_clk) disable iff (rst)
      state_r == S_IDLE && startRise && ctrl_r[CTRL_DRIVE] && chan_r > CHAN_MAX
      |=> errorFlag && faultCode_r == FAULT_BAD_CHANNEL;
   endproperty
   a_bad_chan: assert property (p_bad_chan) else $error("channel fault");

   property p_latch;
      @(posedge core_clk) disable iff (rst)
      $rose(doneFlag) |-> latchedPos_r == $past(trigPos);
   endproperty
   a_latch: assert property (p_latch) else $error("bad latch");

   property p_window;
      @(posedge core_clk) disable iff (rst)
      state_r == S_WAIT && trig && !inWin && !ctrl_r[CTRL_ABORT] |=> !doneFlag;
   endproperty
   a_window: assert property (p_window) else $error("window ignored");

   property p_abort;
      @(posedge core_clk) disable iff (rst)
      (state_r == S_WAIT || state_r == S_ARM) && ctrl_r[CTRL_ABORT] |=> abortedFlag;
   endproperty
   a_abort: assert property (p_abort) else $error("abort lost");

   property p_error_clear;
      @(posedge core_clk) disable iff (rst)
      errorFlag && !ctrl_r[CTRL_START] |=> !errorFlag && faultCode_r == FAULT_NONE;
   endproperty
   a_error_clear: assert property (p_error_clear) else $error("error held");

   sequence s_abort_held;
      abortedFlag && !ctrl_r[CTRL_START];
   endsequence

   property p_abort_clear;
      @(posedge core_clk) disable iff (rst)
      s_abort_held |=> !abortedFlag;
   endproperty
   a_abort_clear: assert property (p_abort_clear) else $error("aborted held");

   property p_probe_off;
      @(posedge core_clk) disable iff (rst)
      state_r == S_IDLE |-> probeFunction == PROBE_OFF;
   endproperty
   a_probe_off: assert property (p_probe_off) else $error("channel left open");

   sequence s_drive_start;
      state_r == S_IDLE && startRise && ctrl_r[CTRL_DRIVE] && chan_r <= CHAN_MAX &&
      (!ctrl_r[CTRL_WIN] || WINDOW_SUPPORTED);
   endsequence

   property p_drive_open;
      @(posedge core_clk) disable iff (rst)
      s_drive_start |=> busyFlag && (probeFunction & PROBE_ENABLE_BIT) != PROBE_OFF &&
      (probeFunction & ~PROBE_ENABLE_BIT) != PROBE_OFF;
   endproperty
   a_drive_open: assert property (p_drive_open) else $error("channel not opened");

   property p_first_only;
      @(posedge core_clk) disable iff (rst)
      state_r == S_END |=> $stable(latchedPos_r);
   endproperty
   a_first_only: assert property (p_first_only) else $error("second capture");

   sequence s_win_arming;
      state_r == S_ARM && ctrl_r[CTRL_WIN] && armCnt_r < 4'(ARM_DELAY);
   endsequence

   property p_arm_delay;
      @(posedge core_clk) disable iff (rst)
      s_win_arming |=> !triggerValid;
   endproperty
   a_arm_delay: assert property (p_arm_delay) else $error("armed early");

   property p_tv_drop;
      @(posedge core_clk) disable iff (rst)
      doneFlag || abortedFlag || errorFlag |-> !triggerValid;
   endproperty
   a_tv_drop: assert property (p_tv_drop) else $error("trigger still valid");

   sequence s_window_refused;
      state_r == S_IDLE && startRise && ctrl_r[CTRL_DRIVE] && chan_r <= CHAN_MAX &&
      ctrl_r[CTRL_WIN] && !WINDOW_SUPPORTED;
   endsequence

   property p_window_fault;
      @(posedge core_clk) disable iff (rst)
      s_window_refused |=> errorFlag && faultCode_r == FAULT_WINDOW_UNSUPPORTED;
   endproperty
   a_window_fault: assert property (p_window_fault) else $error("window fault");

   sequence s_soft_hit;
      state_r == S_WAIT && !ctrl_r[CTRL_DRIVE] && softRise && inWin && !ctrl_r[CTRL_ABORT];
   endsequence

   property p_soft_latch;
      @(posedge core_clk) disable iff (rst)
      s_soft_hit |=> doneFlag && latchedPos_r == $past(cmdPosition);
   endproperty
   a_soft_latch: assert property (p_soft_latch) else $error("soft latch lost");
endmodule

// ---- testbench/aptp_drive_model.sv ----
// Servo drive touch probe latch model
`timescale 1ns/1ps
module aptp_drive_model
   import aptp_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Bench control
   input wire logic fire,
   input wire logic multiTrig,
   input wire logic [POS_W-1:0] latchPos,
   // Drive side
   input wire logic [15:0] probeFunction,
   output logic probeLatched,
   output logic [POS_W-1:0] probePosition
);
   logic [3:0] holdCnt_r;
   // Latch only on an opened channel unless repeat triggering is commanded
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         holdCnt_r <= 4'h0;
         probeLatched <= 1'b0;
         probePosition <= 32'h0000_0000;
      end
      else if (fire && (multiTrig || (probeFunction[0] && |probeFunction[7:4])))
      begin
         holdCnt_r <= 4'h8;
         probeLatched <= 1'b1;
         probePosition <= latchPos;
      end
      else if (holdCnt_r == 4'h1)
      begin
         holdCnt_r <= 4'h0;
         probeLatched <= 1'b0;
         probePosition <= ~probePosition;
      end
      else if (holdCnt_r != 4'h0)
         holdCnt_r <= holdCnt_r - 4'h1;
   end
endmodule

// ---- testbench/tb_axis_position_touch_probe.sv ----
// Testbench of the position latch block
`timescale 1ns/1ps
module tb_axis_position_touch_probe
   import aptp_pkg::*;
;
   logic core_clk, rst, cyc, stb, we, fire, multiTrig;
   logic [WB_AW-1:0] adr;
   logic [31:0] datW, datR, q, p, q2, datR2;
   logic ack, pLat, tv, dn, bz, er, ab;
   logic [POS_W-1:0] cmdPos, latchPos, pPos;
   logic [15:0] pFunc;
   int err_count, cmp_count;
   wire logic [4:0] st = {tv, ab, er, bz, dn};

   aptp_touch_probe DUT (.core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(datW), .wb_dat_o(datR),
      .wb_ack_o(ack), .cmdPosition(cmdPos), .actPosition(cmdPos), .probeLatched(pLat),
      .probePosition(pPos), .probeFunction(pFunc), .triggerValid(tv), .doneFlag(dn),
      .busyFlag(bz), .errorFlag(er), .abortedFlag(ab));
   aptp_drive_model DRV (.core_clk(core_clk), .rst(rst), .fire(fire), .multiTrig(multiTrig),
      .latchPos(latchPos), .probeFunction(pFunc), .probeLatched(pLat), .probePosition(pPos));
   aptp_touch_probe #(.WINDOW_SUPPORTED(1'b0)) DUT_NOWIN (.core_clk(core_clk), .rst(rst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(datW), .wb_dat_o(datR2), .wb_ack_o(), .cmdPosition(cmdPos),
      .actPosition(cmdPos), .probeLatched(pLat), .probePosition(pPos), .probeFunction(),
      .triggerValid(), .doneFlag(), .busyFlag(), .errorFlag(), .abortedFlag());

   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   task automatic xfer(input logic w, input logic [WB_AW-1:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      datW <= d;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      chk("bus ack", 32'h0000_0001, {31'h0, ack});
      q = datR;
      q2 = datR2;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rdchk(input string nm, input logic [WB_AW-1:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0000_0000);
      chk(nm, e, q);
   endtask

   task automatic wait_bit(input int b);
      int n;
      n = 0;
      while (st[b] !== 1'b1 && n < 60)
      begin
         @(posedge core_clk);
         n++;
      end
      chk("flag wait", 32'h0000_0001, {31'h0, st[b]});
   endtask

   task automatic fire_drive(input logic [31:0] pos);
      @(posedge core_clk);
      fire <= 1'b1;
      latchPos <= pos;
      @(posedge core_clk);
      fire <= 1'b0;
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      {cyc, stb, we, fire, multiTrig} = 5'h00;
      adr = 4'h0;
      datW = 32'h0000_0000;
      cmdPos = 32'h0000_0000;
      latchPos = 32'h0000_0000;
      err_count = 0;
      cmp_count = 0;
      rst = 1'b1;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      rdchk("status", REG_STATUS, 32'h0000_0000);
      rdchk("position", REG_POS, 32'h0000_0000);
      rdchk("unmapped", 4'h6, 32'h0000_0000);
      xfer(1'b1, REG_CTRL, 32'h0000_0003);
      wait_bit(2);
      rdchk("fault", REG_STATUS, {FAULT_BAD_CHANNEL, 16'h0004});
      xfer(1'b1, REG_CTRL, 32'h0000_0002);
      repeat (2) @(posedge core_clk);
      rdchk("fault clear", REG_STATUS, 32'h0000_0000);
      for (int c = 0; c <= 3; c++)
      begin
         p = 32'h1000_0000 + c;
         xfer(1'b1, REG_CHAN, c);
         xfer(1'b1, REG_CTRL, 32'h0000_0003);
         wait_bit(4);
         chk("probe function", 16'h0001 | (16'h0010 << c), pFunc);
         fire_drive(p);
         wait_bit(0);
         chk("busy", 32'h0000_0000, bz);
         rdchk("drive position", REG_POS, p);
         multiTrig <= 1'b1;
         fire_drive(32'h2222_0000);
         repeat (12) @(posedge core_clk);
         multiTrig <= 1'b0;
         rdchk("first only", REG_POS, p);
         xfer(1'b1, REG_CTRL, 32'h0000_0002);
         repeat (2) @(posedge core_clk);
         chk("done clear", 32'h0000_0000, dn);
      end
      xfer(1'b1, 4'h1, 32'h0000_0064);
      xfer(1'b1, 4'h2, 32'h0000_00C8);
      cmdPos <= 32'h0000_0032;
      xfer(1'b1, REG_CTRL, 32'h0000_0005);
      wait_bit(1);
      wait_bit(4);
      xfer(1'b1, REG_CTRL, 32'h0000_000D);
      xfer(1'b1, REG_CTRL, 32'h0000_0005);
      repeat (3) @(posedge core_clk);
      chk("outside window", 32'h0000_0000, dn);
      cmdPos <= 32'h0000_0096;
      xfer(1'b1, REG_CTRL, 32'h0000_000D);
      wait_bit(0);
      rdchk("command position", REG_POS, 32'h0000_0096);
      xfer(1'b1, REG_CTRL, 32'h0000_0000);
      xfer(1'b1, REG_CTRL, 32'h0000_0001);
      wait_bit(1);
      xfer(1'b1, REG_CTRL, 32'h0000_0011);
      wait_bit(3);
      chk("busy after abort", 32'h0000_0000, bz);
      xfer(1'b1, REG_CTRL, 32'h0000_0000);
      repeat (2) @(posedge core_clk);
      chk("aborted clear", 32'h0000_0000, ab);
      xfer(1'b1, REG_CTRL, 32'h0000_0001);
      wait_bit(4);
      xfer(1'b1, REG_CTRL, 32'h0000_0000);
      xfer(1'b1, REG_CTRL, 32'h0000_0008);
      wait_bit(0);
      @(posedge core_clk);
      chk("done pulse", 32'h0000_0000, dn);
      xfer(1'b1, REG_CTRL, 32'h0000_0000);
      p = 32'h3000_0000;
      xfer(1'b1, REG_CTRL, 32'h0000_0007);
      wait_bit(4);
      xfer(1'b0, REG_STATUS, 32'h0000_0000);
      chk("window fault", {FAULT_WINDOW_UNSUPPORTED, 16'h0004}, q2);
      fire_drive(p);
      wait_bit(0);
      rdchk("drive window position", REG_POS, p);
      xfer(1'b1, REG_CTRL, 32'h0000_0002);
      repeat (2) @(posedge core_clk);
      xfer(1'b0, REG_STATUS, 32'h0000_0000);
      chk("window fault clear", 32'h0000_0000, q2);
      finish_test();
   end

   initial
   begin
      #20000;
      err_count++;
      finish_test();
   end
endmodule
